// >>> design/ebpc_params.svh
// Register offsets, field positions, reset values and codes of the bus pin configuration
`ifndef EBPC_PARAMS_SVH
`define EBPC_PARAMS_SVH
`define EBPC_OFFS_PRIMARY     4'h0
`define EBPC_OFFS_SECONDARY   4'h4
`define EBPC_RST_PRIMARY      16'h00F0
`define EBPC_RST_SECONDARY    16'h0000
`define EBPC_MASK_SECONDARY   16'h005F
`define EBPC_BIT_RDY_POL      15
`define EBPC_BIT_RDY_DIS      14
`define EBPC_BIT_ALE_DIS      13
`define EBPC_BIT_BYTE_DIS     12
`define EBPC_BIT_WR_CFG       11
`define EBPC_BIT_BUS_DIS      10
`define EBPC_BIT_SLAVE        9
`define EBPC_BIT_ARB_EN       8
`define EBPC_CS_MSB           7
`define EBPC_CS_LSB           4
`define EBPC_SEG_MSB          3
`define EBPC_SEG_LSB          0
`define EBPC_BIT_DHI_DIS      6
`define EBPC_APD_MSB          4
`define EBPC_APD_LSB          0
`define EBPC_CODE_MAX         4'h8
`define EBPC_CS_EFF_RST       4'h8
`define EBPC_SEG_EFF_RST      4'h0
`define EBPC_APD_ALL_ON       5'h00
`define EBPC_APD_ALL_OFF      5'h1F
`define EBPC_RESP_OKAY        2'h0
`define EBPC_RESP_SLVERR      2'h2
`endif

// >>> design/ebpc_pkg.sv
// Types shared by the bus pin configuration block
package ebpc_pkg;
  typedef logic [15:0] ebpc_reg_t;   // One mode register
  typedef logic [3:0]  ebpc_code_t;  // Pin count code
  typedef logic [7:0]  ebpc_pins8_t; // Eight pin enables
  typedef logic [15:0] ebpc_pins16_t; // Sixteen pin enables
endpackage : ebpc_pkg

// >>> design/ebpc_ext_bus_pin_config.sv
// External bus pin configuration: mode registers, AXI4-Lite slave, pin ownership
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/10ps
`include "ebpc_params.svh"

// Operation
// - Bit 15 selects ready input polarity
// - Bits 14..12 release ready, latch, byte-high
// - Bit 10 releases all bus pins
// - Bit 11 picks write/byte-high or byte strobes
// - Strobe style changes at next access start
// - Bit 9 makes arbiter master or slave
// - Bit 8 enables hold, acknowledge, request pins
// - Bits 7..4 enable chip selects from zero
// - Bits 3..0 enable segment lines from 16
// - Second register bit 6 releases data 15..8
// - Bits 4..0 all-zero keep, all-one release addresses
// - Demultiplexed access without address pins shows none
// - Second register reserved bits read zero
// - Strobes follow written bytes, not address bit 0
// - End of initialization locks both registers
module ebpc_ext_bus_pin_config (
  input  wire logic               clock,           // System clock, 25 MHz
  input  wire logic               arst_n,          // Asynchronous reset, active low
  // AXI4-Lite slave
  input  wire logic [3:0]         s_axi_awaddr,    // Write address
  input  wire logic               s_axi_awvalid,   // Write address valid
  output logic                    s_axi_awready,   // Write address ready
  input  wire logic [31:0]        s_axi_wdata,     // Write data
  input  wire logic [3:0]         s_axi_wstrb,     // Write byte strobes
  input  wire logic               s_axi_wvalid,    // Write data valid
  output logic                    s_axi_wready,    // Write data ready
  output logic [1:0]              s_axi_bresp,     // Write response
  output logic                    s_axi_bvalid,    // Write response valid
  input  wire logic               s_axi_bready,    // Write response ready
  input  wire logic [3:0]         s_axi_araddr,    // Read address
  input  wire logic               s_axi_arvalid,   // Read address valid
  output logic                    s_axi_arready,   // Read address ready
  output logic [31:0]             s_axi_rdata,     // Read data
  output logic [1:0]              s_axi_rresp,     // Read response
  output logic                    s_axi_rvalid,    // Read response valid
  input  wire logic               s_axi_rready,    // Read response ready
  // Core and access engine side
  input  wire logic               initDone,        // End-of-initialization instruction pulse
  input  wire logic               accessStart,     // Pulse: external access begins
  input  wire logic               accessActive,    // External access under way
  input  wire logic               accessMux,       // Access is multiplexed
  input  wire logic               accessWrite,     // Access is a write
  input  wire logic               cmdActive,       // Command phase active
  input  wire logic               byteLow,         // Low byte involved
  input  wire logic               byteHigh,        // High byte involved
  input  wire logic               accessAddr0,     // Address bit 0 of the access
  input  wire logic               busNeeded,       // Device wants the shared bus
  output logic                    readyAsserted,   // Ready seen, polarity applied
  output logic                    addressPresent,  // Low address driven this access
  output logic                    arbiterSlave,    // Arbiter in slave role
  // Pins
  input  wire logic               readyPin,        // Ready input pin
  input  wire logic               holdRequestN,    // Foreign hold request, active low
  output logic                    readyPinEnable,  // Ready pin owned by bus
  output logic                    latchStrobeEnable, // Latch strobe pin owned
  output logic                    byteHighPinEnable, // Byte-high pin owned
  output logic                    arbPinsEnable,   // Arbitration pins owned
  output logic                    holdAcknowledgeN, // Hold acknowledge, active low
  output logic                    busRequestOutN,  // Bus request, active low
  output logic                    writeStrobeN,    // General or low-byte write strobe
  output logic                    byteHighStrobeN, // Byte-high enable or high-byte strobe
  output logic                    addrBit0,        // Address bit 0 driven on bus
  output ebpc_pkg::ebpc_pins8_t   chipSelectEnable, // Chip-select pin enables
  output ebpc_pkg::ebpc_pins8_t   segmentAddrEnable, // Address 23..16 enables
  output logic                    upperDataEnable, // Data 15..8 owned
  output ebpc_pkg::ebpc_pins16_t  lowAddrEnable    // Address 15..0 enables
);
  import ebpc_pkg::*;

  ebpc_reg_t  modePrimary;      // First mode register
  ebpc_reg_t  modeSecondary;    // Second mode register
  ebpc_code_t csCode;           // Last valid chip-select code
  ebpc_code_t segCode;          // Last valid segment code
  logic       lowAddrOff;       // Last valid low-address release
  logic       writeSeparate;    // Strobe style in force
  logic       locked;           // Writes blocked after init
  logic       awHeld;           // Write address captured
  logic       wHeld;            // Write data captured
  logic [3:0] awAddr;           // Captured write address
  logic [31:0] wData;           // Captured write data
  logic [3:0] wStrb;            // Captured strobes
  logic       doWrite;          // Both halves present
  logic       busOn;            // Bus pins not released
  logic [1:0] readySync;        // Ready synchroniser
  logic [1:0] holdSync;         // Hold request synchroniser
  logic       holdReq;          // Hold request, active high
  ebpc_reg_t  next_primary;     // Primary after byte merge
  ebpc_reg_t  next_secondary;   // Secondary after byte merge

  // Write channel handshakes: take each half once, respond after both
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;

  // Capture address and data in either order
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awAddr <= 4'h0;
      wData  <= 32'h0000_0000;
      wStrb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
    end
  end

  // Write response one cycle after both halves held
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `EBPC_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awAddr == `EBPC_OFFS_PRIMARY || awAddr == `EBPC_OFFS_SECONDARY)
                      ? `EBPC_RESP_OKAY : `EBPC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Byte-lane merge of the written word
  always_comb begin
    next_primary   = modePrimary;
    next_secondary = modeSecondary;
    if (wStrb[0]) begin
      next_primary[7:0]   = wData[7:0];
      next_secondary[7:0] = wData[7:0];
    end
    if (wStrb[1]) begin
      next_primary[15:8]   = wData[15:8];
      next_secondary[15:8] = wData[15:8];
    end
    next_secondary = next_secondary & `EBPC_MASK_SECONDARY;
  end

  // Mode registers, frozen once initialization has ended
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      modePrimary   <= `EBPC_RST_PRIMARY;
      modeSecondary <= `EBPC_RST_SECONDARY;
    end else if (doWrite && !locked) begin
      if (awAddr == `EBPC_OFFS_PRIMARY) begin
        modePrimary <= next_primary;
      end
      if (awAddr == `EBPC_OFFS_SECONDARY) begin
        modeSecondary <= next_secondary;
      end
    end
  end

  // Lock flag: set by the init instruction, cleared only by reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      locked <= 1'b0;
    end else if (initDone) begin
      locked <= 1'b1;
    end
  end

  // Effective pin counts hold the last defined code
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      csCode     <= `EBPC_CS_EFF_RST;
      segCode    <= `EBPC_SEG_EFF_RST;
      lowAddrOff <= 1'b0;
    end else begin
      if (modePrimary[`EBPC_CS_MSB:`EBPC_CS_LSB] <= `EBPC_CODE_MAX) begin
        csCode <= modePrimary[`EBPC_CS_MSB:`EBPC_CS_LSB];
      end
      if (modePrimary[`EBPC_SEG_MSB:`EBPC_SEG_LSB] <= `EBPC_CODE_MAX) begin
        segCode <= modePrimary[`EBPC_SEG_MSB:`EBPC_SEG_LSB];
      end
      if (modeSecondary[`EBPC_APD_MSB:`EBPC_APD_LSB] == `EBPC_APD_ALL_ON) begin
        lowAddrOff <= 1'b0;
      end else if (modeSecondary[`EBPC_APD_MSB:`EBPC_APD_LSB] == `EBPC_APD_ALL_OFF) begin
        lowAddrOff <= 1'b1;
      end
    end
  end

  // Strobe style taken over only when an access begins
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      writeSeparate <= 1'b0;
    end else if (accessStart) begin
      writeSeparate <= modePrimary[`EBPC_BIT_WR_CFG];
    end
  end

  // Read channel: one read at a time, data one cycle after address
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `EBPC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      // Stored contents in the low half, upper half zero
      case (s_axi_araddr)
        `EBPC_OFFS_PRIMARY: begin
          s_axi_rdata <= {16'h0000, modePrimary};
          s_axi_rresp <= `EBPC_RESP_OKAY;
        end
        `EBPC_OFFS_SECONDARY: begin
          s_axi_rdata <= {16'h0000, modeSecondary};
          s_axi_rresp <= `EBPC_RESP_OKAY;
        end
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `EBPC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Pin inputs pass two flip-flops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      readySync <= 2'b00;
      holdSync  <= 2'b11;
    end else begin
      readySync <= {readySync[0], readyPin};
      holdSync  <= {holdSync[0], holdRequestN};
    end
  end

  // Pin ownership, all released while bus pins are disabled
  assign busOn             = !modePrimary[`EBPC_BIT_BUS_DIS];
  assign readyPinEnable    = busOn && !modePrimary[`EBPC_BIT_RDY_DIS];
  assign latchStrobeEnable = busOn && !modePrimary[`EBPC_BIT_ALE_DIS];
  assign byteHighPinEnable = busOn && !modePrimary[`EBPC_BIT_BYTE_DIS];
  assign arbPinsEnable     = busOn && modePrimary[`EBPC_BIT_ARB_EN];
  assign arbiterSlave      = modePrimary[`EBPC_BIT_SLAVE];
  assign upperDataEnable   = busOn && !modeSecondary[`EBPC_BIT_DHI_DIS];
  assign readyAsserted     = readyPinEnable &&
                             (readySync[1] == modePrimary[`EBPC_BIT_RDY_POL]);

  // Thermometer decode of chip-select and segment counts, per pin
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      assign chipSelectEnable[gi]  = busOn && (csCode > 4'(gi));
      assign segmentAddrEnable[gi] = busOn && (segCode > 4'(gi));
    end
  endgenerate

  assign lowAddrEnable  = {16{busOn && !lowAddrOff}};
  assign addressPresent = accessActive && (accessMux || lowAddrEnable[0]);

  // Arbitration: grant a foreign master when idle, ask back when needed
  assign holdReq          = !holdSync[1];
  assign holdAcknowledgeN = !(arbPinsEnable && !arbiterSlave && holdReq
                              && !accessActive);
  assign busRequestOutN   = !(arbPinsEnable && busNeeded &&
                              (arbiterSlave || !holdAcknowledgeN));

  // Write strobes in the style now in force
  always_comb begin
    if (writeSeparate) begin
      writeStrobeN    = !(cmdActive && accessWrite && byteLow);
      byteHighStrobeN = !(cmdActive && accessWrite && byteHigh);
      addrBit0        = accessAddr0;
    end else begin
      writeStrobeN    = !(cmdActive && accessWrite && (byteLow || byteHigh));
      byteHighStrobeN = !(cmdActive && byteHigh && byteHighPinEnable);
      addrBit0        = byteHigh && !byteLow;
    end
  end

  // Checks
  sequence s_wr_primary;
    doWrite && !locked && awAddr == `EBPC_OFFS_PRIMARY && wStrb[1];
  endsequence
  sequence s_locked_write;
    locked && doWrite;
  endsequence

  chk_lock_blocks: assert property (@(posedge clock) disable iff (!arst_n)
    s_locked_write |=> $stable(modePrimary) && $stable(modeSecondary))
    else $error("Mode register changed after lock");
  chk_primary_write: assert property (@(posedge clock) disable iff (!arst_n)
    s_wr_primary |=> modePrimary[15:8] == $past(wData[15:8]))
    else $error("Primary high byte not written");
  chk_reserved_zero: assert property (@(posedge clock) disable iff (!arst_n)
    (modeSecondary & ~`EBPC_MASK_SECONDARY) == 16'h0000)
    else $error("Reserved secondary bits set");
  chk_style_hold: assert property (@(posedge clock) disable iff (!arst_n)
    !accessStart |=> $stable(writeSeparate))
    else $error("Strobe style changed outside access start");
  chk_bus_release: assert property (@(posedge clock) disable iff (!arst_n)
    modePrimary[`EBPC_BIT_BUS_DIS] |-> !readyPinEnable && chipSelectEnable == 8'h00
    && lowAddrEnable == 16'h0000 && !arbPinsEnable)
    else $error("Pins owned while bus disabled");
  chk_cs_count: assert property (@(posedge clock) disable iff (!arst_n)
    busOn && csCode == 4'h1 |-> chipSelectEnable == 8'h01)
    else $error("Chip-select code one wrong");
  chk_seg_keep: assert property (@(posedge clock) disable iff (!arst_n)
    modePrimary[3:0] > `EBPC_CODE_MAX |=> $stable(segCode))
    else $error("Reserved segment code changed pins");
  chk_ready_pol: assert property (@(posedge clock) disable iff (!arst_n)
    readyPinEnable && !modePrimary[`EBPC_BIT_RDY_POL] && !readySync[1] |-> readyAsserted)
    else $error("Low ready not seen in low polarity");
  chk_general_a0: assert property (@(posedge clock) disable iff (!arst_n)
    !writeSeparate && byteLow |-> !addrBit0)
    else $error("Address bit 0 set for low byte");
  chk_no_address: assert property (@(posedge clock) disable iff (!arst_n)
    accessActive && !accessMux && lowAddrOff |-> !addressPresent)
    else $error("Address shown with pins disabled");
  chk_hold_ack: assert property (@(posedge clock) disable iff (!arst_n)
    !arbPinsEnable |-> holdAcknowledgeN && busRequestOutN)
    else $error("Arbitration active while disabled");
endmodule : ebpc_ext_bus_pin_config

// >>> dv/ebpc_bus_partner.sv
// Model of the external bus devices: ready source and foreign hold requester
`timescale 1ns/10ps
module ebpc_bus_partner (
  input  wire logic clock,         // System clock
  input  wire logic readyWanted,   // Device should see ready asserted
  input  wire logic readyHighSense, // Ready sense currently programmed
  input  wire logic holdWanted,    // Foreign master wants the bus
  output logic      readyPin,      // Ready line to the device
  output logic      holdRequestN   // Hold request, active low
);
  // Ready drive follows the programmed sense; hold request asserted low
  always @(posedge clock) begin
    readyPin     <= readyWanted ~^ readyHighSense;
    holdRequestN <= !holdWanted;
  end
endmodule : ebpc_bus_partner

// >>> dv/ebpc_ext_bus_pin_config_tb.sv
// Self-checking bench of the bus pin configuration block
`timescale 1ns/10ps
`include "ebpc_params.svh"
module ebpc_ext_bus_pin_config_tb;
  import ebpc_pkg::*;
  logic clock = 0, arst_n = 0;
  logic [3:0] awaddr = 0, araddr = 0, wstrb = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] bresp, rresp;
  logic initDone = 0, accessStart = 0, accessActive = 0, accessMux = 0, accessWrite = 0;
  logic cmdActive = 0, byteLow = 0, byteHigh = 0, accessAddr0 = 0, busNeeded = 0;
  logic readyWanted = 0, readyHighSense = 0, holdWanted = 0, readyPin, holdRequestN;
  logic readyAsserted, addressPresent, arbiterSlave, readyPinEnable, latchStrobeEnable;
  logic byteHighPinEnable, arbPinsEnable, holdAcknowledgeN, busRequestOutN, writeStrobeN;
  logic byteHighStrobeN, addrBit0, upperDataEnable;
  ebpc_pins8_t chipSelectEnable, segmentAddrEnable;
  ebpc_pins16_t lowAddrEnable;
  logic [1:0] bq[$];   // Expected write responses
  logic [33:0] rq[$];  // Expected read response and data
  int nMismatch = 0, samplesChecked = 0;
  logic [31:0] seed = 32'd131;
  always #20 clock = ~clock;
  ebpc_ext_bus_pin_config dut (.clock(clock), .arst_n(arst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .initDone(initDone), .accessStart(accessStart),
    .accessActive(accessActive), .accessMux(accessMux), .accessWrite(accessWrite),
    .cmdActive(cmdActive), .byteLow(byteLow), .byteHigh(byteHigh), .accessAddr0(accessAddr0),
    .busNeeded(busNeeded), .readyAsserted(readyAsserted), .addressPresent(addressPresent),
    .arbiterSlave(arbiterSlave), .readyPin(readyPin), .holdRequestN(holdRequestN),
    .readyPinEnable(readyPinEnable), .latchStrobeEnable(latchStrobeEnable),
    .byteHighPinEnable(byteHighPinEnable), .arbPinsEnable(arbPinsEnable),
    .holdAcknowledgeN(holdAcknowledgeN), .busRequestOutN(busRequestOutN),
    .writeStrobeN(writeStrobeN), .byteHighStrobeN(byteHighStrobeN), .addrBit0(addrBit0),
    .chipSelectEnable(chipSelectEnable), .segmentAddrEnable(segmentAddrEnable),
    .upperDataEnable(upperDataEnable), .lowAddrEnable(lowAddrEnable));
  ebpc_bus_partner partner (.clock(clock), .readyWanted(readyWanted),
    .readyHighSense(readyHighSense), .holdWanted(holdWanted), .readyPin(readyPin),
    .holdRequestN(holdRequestN));
  // Xorshift source for the ignored upper data lanes
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // Thermometer of n enables from bit 0 upward
  function automatic logic [15:0] th(int n);
    return 16'((17'h1 << n) - 1);
  endfunction : th
  // Compare one value
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // AXI4-Lite write; the response is noted for the monitor
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] r);
    logic aw, w;
    bq.push_back(r);
    @(posedge clock);
    awaddr <= a; awvalid <= 1; wstrb <= 4'h3; wvalid <= 1; bready <= 1;
    wdata <= {rnd() & 32'hFFFF_0000} | {16'h0000, d};
    aw = 1; w = 1;
    while (aw || w) begin
      @(negedge clock);
      if (aw && awready) aw = 0;
      if (w && wready) w = 0;
      @(posedge clock);
      if (!aw) awvalid <= 0;
      if (!w) wvalid <= 0;
    end
    do @(negedge clock); while (!bvalid);
    @(posedge clock) bready <= 0;
  endtask : wr
  // AXI4-Lite read; data and response are noted for the monitor
  task automatic rd(input logic [3:0] a, input logic [15:0] d, input logic [1:0] r);
    rq.push_back({r, 16'h0000, d});
    @(posedge clock);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(negedge clock); while (!arready);
    @(posedge clock) arvalid <= 0;
    do @(negedge clock); while (!rvalid);
    @(posedge clock) rready <= 0;
  endtask : rd
  // Let register and code flops land, then look at settled outputs
  task automatic settle(int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask : settle
  // Access start pulse
  task automatic start();
    @(posedge clock) accessStart <= 1;
    @(posedge clock) accessStart <= 0;
    settle(1);
  endtask : start
  // Response monitor takes the oldest note at each completed answer
  always @(negedge clock) begin
    if (bvalid && bready) chk(bresp, bq.pop_front());
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
  end
  // Verdict
  task automatic results();
    $display("checked %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  // Watchdog
  initial begin
    repeat (20000) @(posedge clock);
    nMismatch++;
    results();
  end
  // Test sequence
  initial begin
    repeat (6) @(posedge clock);
    arst_n <= 1;
    rd(4'h0, `EBPC_RST_PRIMARY, `EBPC_RESP_OKAY);
    rd(4'h4, 16'h0000, `EBPC_RESP_OKAY);
    settle(0);
    chk(chipSelectEnable, 8'hFF);
    chk(lowAddrEnable, 16'hFFFF);
    $display("reset values done");
    for (int i = 0; i <= 8; i++) begin
      wr(4'h0, {8'h00, 4'(i), 4'(8 - i)}, `EBPC_RESP_OKAY);
      settle(1);
      chk(chipSelectEnable, th(i) & 16'hFF);
      chk(segmentAddrEnable, th(8 - i) & 16'hFF);
    end
    wr(4'h0, 16'h0099, `EBPC_RESP_OKAY);
    rd(4'h0, 16'h0099, `EBPC_RESP_OKAY);
    settle(1);
    chk({chipSelectEnable, segmentAddrEnable}, 16'hFF00);
    $display("pin counts done");
    wr(4'h0, 16'h7300, `EBPC_RESP_OKAY);
    settle(0);
    chk({readyPinEnable, latchStrobeEnable, byteHighPinEnable, arbPinsEnable, arbiterSlave},
      5'b00011);
    wr(4'h0, 16'h0500, `EBPC_RESP_OKAY);
    settle(0);
    chk({readyPinEnable, latchStrobeEnable, byteHighPinEnable, arbPinsEnable, arbiterSlave},
      5'b00000);
    wr(4'h0, 16'h0100, `EBPC_RESP_OKAY);
    holdWanted <= 1;
    settle(4);
    chk(holdAcknowledgeN, 1'b0);
    @(posedge clock) busNeeded <= 1;
    settle(0);
    chk(busRequestOutN, 1'b0);
    @(posedge clock);
    busNeeded <= 0;
    holdWanted <= 0;
    settle(4);
    chk({holdAcknowledgeN, busRequestOutN}, 2'b11);
    $display("pin ownership done");
    wr(4'h4, 16'hFFFF, `EBPC_RESP_OKAY);
    rd(4'h4, `EBPC_MASK_SECONDARY, `EBPC_RESP_OKAY);
    settle(1);
    chk({upperDataEnable, lowAddrEnable}, 17'h0);
    @(posedge clock) accessActive <= 1;
    settle(0);
    chk(addressPresent, 1'b0);
    @(posedge clock) accessMux <= 1;
    settle(0);
    chk(addressPresent, 1'b1);
    @(posedge clock);
    accessActive <= 0;
    accessMux <= 0;
    wr(4'h4, 16'h0000, `EBPC_RESP_OKAY);
    settle(1);
    chk({upperDataEnable, lowAddrEnable}, 17'h1FFFF);
    wr(4'h8, 16'h1111, `EBPC_RESP_SLVERR);
    rd(4'h8, 16'h0000, `EBPC_RESP_SLVERR);
    $display("second register done");
    for (int p = 0; p < 2; p++) begin
      wr(4'h0, {1'(p), 15'h0100}, `EBPC_RESP_OKAY);
      readyHighSense <= 1'(p);
      readyWanted <= 1;
      settle(4);
      chk(readyAsserted, 1'b1);
      @(posedge clock) readyWanted <= 0;
      settle(4);
      chk(readyAsserted, 1'b0);
    end
    $display("ready sense done");
    wr(4'h0, 16'h0100, `EBPC_RESP_OKAY);
    accessActive <= 1;
    accessWrite <= 1;
    cmdActive <= 1;
    byteHigh <= 1;
    accessAddr0 <= 1;
    start();
    chk({writeStrobeN, byteHighStrobeN, addrBit0}, 3'b001);
    @(posedge clock) byteLow <= 1;
    settle(0);
    chk({writeStrobeN, byteHighStrobeN, addrBit0}, 3'b000);
    @(posedge clock) byteHigh <= 0;
    settle(0);
    chk({writeStrobeN, byteHighStrobeN, addrBit0}, 3'b010);
    @(posedge clock);
    byteHigh <= 1;
    byteLow <= 0;
    wr(4'h0, 16'h0900, `EBPC_RESP_OKAY);
    settle(0);
    chk({writeStrobeN, byteHighStrobeN, addrBit0}, 3'b001);
    start();
    chk({writeStrobeN, byteHighStrobeN, addrBit0}, 3'b101);
    @(posedge clock) byteLow <= 1;
    settle(0);
    chk({writeStrobeN, byteHighStrobeN, addrBit0}, 3'b001);
    @(posedge clock);
    accessActive <= 0;
    accessWrite <= 0;
    cmdActive <= 0;
    byteHigh <= 0;
    byteLow <= 0;
    $display("strobe style done");
    @(posedge clock) initDone <= 1;
    @(posedge clock) initDone <= 0;
    wr(4'h0, 16'h1234, `EBPC_RESP_OKAY);
    wr(4'h4, 16'h0040, `EBPC_RESP_OKAY);
    rd(4'h0, 16'h0900, `EBPC_RESP_OKAY);
    rd(4'h4, 16'h0000, `EBPC_RESP_OKAY);
    $display("lock done");
    settle(2);
    results();
  end
endmodule : ebpc_ext_bus_pin_config_tb
